/* File: hw/csl_defines.vh */
`ifndef CSL_DEFINES_VH
`define CSL_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSL_OFF_CTRL       12'h000
`define CSL_OFF_COND       12'h004
`define CSL_OFF_STATUS     12'h008
`define CSL_OFF_IRQ_STAT   12'h00c
`define CSL_OFF_IRQ_MASK   12'h010
`define CSL_OFF_NET        12'h014
`define CSL_OFF_ADDR       12'h018
`define CSL_OFF_STORED     12'h01c
`define CSL_OFF_PAUSE_CNT  12'h020
// ----------------------------------------
// ctrl fields
// ----------------------------------------
`define CSL_CTRL_STORED_EN  0
`define CSL_CTRL_DHCP_EN    1
`define CSL_CTRL_INIT_DONE  2
`define CSL_CTRL_RESTART    3
`define CSL_CTRL_RESET      32'h0000_0002
// ----------------------------------------
// cond fields (software-reported conditions)
// ----------------------------------------
`define CSL_COND_FATAL      0
`define CSL_COND_XFER       1
`define CSL_COND_APP        2
`define CSL_COND_ACQ        3
// ----------------------------------------
// net fields (software-reported network answers)
// ----------------------------------------
`define CSL_NET_DHCP_OFFER  0
`define CSL_NET_ARP_REPLY   1
// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define CSL_IRQ_PAUSE       0
`define CSL_IRQ_ADDR_OK     1
`define CSL_IRQ_LINK_CHG    2
`define CSL_IRQ_FATAL       3
`define CSL_IRQ_W           4
// ----------------------------------------
// timing
// ----------------------------------------
`define CSL_CLK_HZ          20000000
`define CSL_GREEN_MS        100
`define CSL_GREEN_CYC       (`CSL_CLK_HZ / 1000 * `CSL_GREEN_MS)
`define CSL_SLOW_MS         500
`define CSL_SLOW_CYC        (`CSL_CLK_HZ / 1000 * `CSL_SLOW_MS)
`define CSL_FAST_MS         100
`define CSL_FAST_CYC        (`CSL_CLK_HZ / 1000 * `CSL_FAST_MS)
`define CSL_RED_MS          250
`define CSL_RED_CYC         (`CSL_CLK_HZ / 1000 * `CSL_RED_MS)
`define CSL_POWER_MS        500
`define CSL_POWER_CYC       (`CSL_CLK_HZ / 1000 * `CSL_POWER_MS)
`define CSL_REBOOT_MS       30000
`define CSL_REBOOT_CYC      (`CSL_CLK_HZ / 1000 * `CSL_REBOOT_MS)
`define CSL_WAIT_MS         2000
`define CSL_WAIT_CYC        (`CSL_CLK_HZ / 1000 * `CSL_WAIT_MS)
`define CSL_LL_NET          16'ha9fe
`endif

/* File: hw/csl_status_ip.v */
`timescale 1ns/1ps
`include "csl_defines.vh"

// Overview of operation
// - received pause frames are counted and raise a sticky pause event bit.
// - led shows pattern of highest-priority active condition.
// - steady red at power-up first; stays steady red only on fatal.
// - red flashes while initialisation runs.
// - fatal shows steady red plus flashing blue, then self-restart under a minute.
// - cable unplugged flashes blue slowly; address configuration waits in the down state until the link returns.
// - file transfer in progress flashes blue quickly.
// - address assigned, no application: steady blue; host access enabled then.
// - application connected steady green; acquisition flashes green, toggles at most per 100 ms.
// - after power-up red, blue flashes while waiting for address configuration.
// - address configuration starts at power-up and on each link connection.
// - try stored address, then dhcp, then link-local, strictly in order.
// - defaults: stored address off, dhcp on; link-local always enabled.
// - dhcp phase broadcasts a request and adopts the server's offered address.
// - link-local picks random candidate inside 169.254 subnet.
// - arp probe for candidate; reply forces new candidate, silence keeps it.
// - link-local address is flagged non-routable.
module csl_status_ip #(
  parameter GREEN_CYC  = `CSL_GREEN_CYC,
  parameter SLOW_CYC   = `CSL_SLOW_CYC,
  parameter FAST_CYC   = `CSL_FAST_CYC,
  parameter RED_CYC    = `CSL_RED_CYC,
  parameter POWER_CYC  = `CSL_POWER_CYC,
  parameter REBOOT_CYC = `CSL_REBOOT_CYC,
  parameter WAIT_CYC   = `CSL_WAIT_CYC
) (
  input  wire        CLK_IN,
  input  wire        SRST_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [11:0] PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  input  wire        LINK_UP_IN,
  input  wire        PAUSE_RX_IN,
  input  wire        FRAME_DONE_IN,
  output reg         LED_RED_OUT,
  output reg         LED_GREEN_OUT,
  output reg         LED_BLUE_OUT,
  output reg         DHCP_REQ_OUT,
  output reg         ARP_PROBE_OUT,
  output reg         HOST_ACCESS_OUT,
  output reg         NON_ROUTABLE_OUT,
  output reg         REBOOT_OUT,
  output reg         IRQ_OUT
);

  // ----------------------------------------
  // address state machine
  // ----------------------------------------
  localparam [6:0] ST_IDLE   = 7'h01;
  localparam [6:0] ST_STORED = 7'h02;
  localparam [6:0] ST_DHCP   = 7'h04;
  localparam [6:0] ST_LLPICK = 7'h08;
  localparam [6:0] ST_ARP    = 7'h10;
  localparam [6:0] ST_DONE   = 7'h20;
  localparam [6:0] ST_DOWN   = 7'h40;

  reg  [31:0] ctrl;
  reg  [3:0]  cond;
  reg  [1:0]  net;
  reg  [31:0] stored_static_address;
  reg  [31:0] ip_addr;
  reg  [31:0] pause_cnt;
  reg  [`CSL_IRQ_W-1:0] irq_stat;
  reg  [`CSL_IRQ_W-1:0] irq_mask;
  reg  [6:0]  state;
  reg  [6:0]  next_state;
  reg  [31:0] wait_cnt;
  reg  [15:0] lfsr;
  reg         link_d;
  reg         link_local_self_assign;
  reg         powered;
  reg  [31:0] power_cnt;
  reg  [31:0] reboot_cnt;
  reg  [31:0] slow_cnt;
  reg  [31:0] fast_cnt;
  reg  [31:0] red_cnt;
  reg  [31:0] green_cnt;
  reg         slow_ph;
  reg         fast_ph;
  reg         red_ph;
  reg         green_ph;
  reg         frame_seen;
  reg         next_r;
  reg         next_g;
  reg         next_b;
  reg  [31:0] rd_data;
  reg  [`CSL_IRQ_W-1:0] ev;

  wire wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
  wire setup    = PSEL_IN & ~PENABLE_IN;
  wire link_rise = LINK_UP_IN & ~link_d;
  wire fatal    = cond[`CSL_COND_FATAL];
  wire init_done = ctrl[`CSL_CTRL_INIT_DONE];
  wire wr_ctrl  = wr_acc && PADDR_IN == `CSL_OFF_CTRL;
  wire restart  = (wr_ctrl && PWDATA_IN[`CSL_CTRL_RESTART]) || link_rise;
  wire wait_over = wait_cnt >= WAIT_CYC - 1;

  // ----------------------------------------
  // apb slave: no wait states, reads registered
  // ----------------------------------------
  always @* begin
    case (PADDR_IN)
      `CSL_OFF_CTRL:      rd_data = ctrl;
      `CSL_OFF_COND:      rd_data = {28'h0000000, cond};
      `CSL_OFF_STATUS:    rd_data = {21'h000000, LINK_UP_IN, NON_ROUTABLE_OUT,
                                     HOST_ACCESS_OUT, state, 1'b0};
      `CSL_OFF_IRQ_STAT:  rd_data = {28'h0000000, irq_stat};
      `CSL_OFF_IRQ_MASK:  rd_data = {28'h0000000, irq_mask};
      `CSL_OFF_NET:       rd_data = {30'h00000000, net};
      `CSL_OFF_ADDR:      rd_data = ip_addr;
      `CSL_OFF_STORED:    rd_data = stored_static_address;
      `CSL_OFF_PAUSE_CNT: rd_data = pause_cnt;
      default:            rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup && PADDR_IN > `CSL_OFF_PAUSE_CNT;
      if (setup)
        PRDATA_OUT <= rd_data;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ctrl  <= `CSL_CTRL_RESET;
      cond  <= 4'h0;
      net   <= 2'b00;
      stored_static_address <= 32'h0000_0000;
      irq_mask <= {`CSL_IRQ_W{1'b0}};
    end else if (wr_acc) begin
      case (PADDR_IN)
        `CSL_OFF_CTRL:     ctrl <= {28'h0000000, 1'b0, PWDATA_IN[2:0]};
        `CSL_OFF_COND:     cond <= PWDATA_IN[3:0];
        `CSL_OFF_NET:      net  <= PWDATA_IN[1:0];
        `CSL_OFF_STORED:   stored_static_address <= PWDATA_IN;
        `CSL_OFF_IRQ_MASK: irq_mask <= PWDATA_IN[`CSL_IRQ_W-1:0];
        default:           ;
      endcase
    end else if (state == ST_ARP || state == ST_DHCP || state == ST_IDLE) begin
      net <= 2'b00; // stale answers must not end a fresh attempt
    end
  end

  // ----------------------------------------
  // events: sticky, write one to clear, set wins
  // ----------------------------------------
  always @* begin
    ev = {`CSL_IRQ_W{1'b0}};
    ev[`CSL_IRQ_PAUSE]    = PAUSE_RX_IN;
    ev[`CSL_IRQ_ADDR_OK]  = state != ST_DONE && next_state == ST_DONE;
    ev[`CSL_IRQ_LINK_CHG] = LINK_UP_IN ^ link_d;
    ev[`CSL_IRQ_FATAL]    = fatal && reboot_cnt == 32'h0000_0000;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CSL_IRQ_W; gi = gi + 1) begin : g_irq
      always @(posedge CLK_IN) begin
        if (SRST_IN)
          irq_stat[gi] <= 1'b0;
        else if (ev[gi])
          irq_stat[gi] <= 1'b1;
        else if (wr_acc && PADDR_IN == `CSL_OFF_IRQ_STAT && PWDATA_IN[gi])
          irq_stat[gi] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      IRQ_OUT   <= 1'b0;
      pause_cnt <= 32'h0000_0000;
      link_d    <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_stat & irq_mask);
      link_d  <= LINK_UP_IN;
      if (PAUSE_RX_IN)
        pause_cnt <= pause_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // address configuration
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!LINK_UP_IN)
          next_state = ST_DOWN;
        else if (init_done)
          next_state = ST_STORED;
      end
      ST_STORED: begin
        if (ctrl[`CSL_CTRL_STORED_EN])
          next_state = ST_DONE;
        else if (ctrl[`CSL_CTRL_DHCP_EN])
          next_state = ST_DHCP;
        else
          next_state = ST_LLPICK;
      end
      ST_DHCP: begin
        if (net[`CSL_NET_DHCP_OFFER])
          next_state = ST_DONE;
        else if (wait_over)
          next_state = ST_LLPICK;
      end
      ST_LLPICK:
        next_state = ST_ARP;
      ST_ARP: begin
        if (net[`CSL_NET_ARP_REPLY])
          next_state = ST_LLPICK;
        else if (wait_over)
          next_state = ST_DONE;
      end
      ST_DONE:
        next_state = ST_DONE;
      ST_DOWN:
        next_state = ST_DOWN;
      default:
        next_state = ST_IDLE;
    endcase
    if (state != ST_IDLE && state != ST_DOWN && !LINK_UP_IN)
      next_state = ST_DOWN;
    if (restart || (state == ST_DOWN && LINK_UP_IN))
      next_state = ST_IDLE;
  end

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state    <= ST_IDLE;
      wait_cnt <= 32'h0000_0000;
      lfsr     <= 16'h5a3c;
      ip_addr  <= 32'h0000_0000;
      link_local_self_assign <= 1'b0;
      DHCP_REQ_OUT  <= 1'b0;
      ARP_PROBE_OUT <= 1'b0;
      HOST_ACCESS_OUT  <= 1'b0;
      NON_ROUTABLE_OUT <= 1'b0;
    end else begin
      state <= next_state;
      lfsr  <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      wait_cnt <= (next_state != state) ? 32'h0000_0000 : wait_cnt + 32'h0000_0001;
      DHCP_REQ_OUT  <= state != ST_DHCP && next_state == ST_DHCP;
      ARP_PROBE_OUT <= state == ST_LLPICK;
      if (state == ST_STORED && next_state == ST_DONE)
        ip_addr <= stored_static_address;
      if (state == ST_DHCP && next_state == ST_DONE)
        ip_addr <= stored_static_address; // offered address written there by software
      if (state == ST_LLPICK) begin
        ip_addr <= {`CSL_LL_NET, lfsr};
        link_local_self_assign <= 1'b1;
      end
      if (next_state == ST_IDLE || next_state == ST_DOWN) begin
        link_local_self_assign <= 1'b0;
        ip_addr <= 32'h0000_0000;
      end
      HOST_ACCESS_OUT  <= next_state == ST_DONE;
      NON_ROUTABLE_OUT <= next_state == ST_DONE && link_local_self_assign &&
                          state != ST_STORED && state != ST_DHCP;
    end
  end

  // ----------------------------------------
  // flash dividers; free-running phases
  // ----------------------------------------
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      slow_cnt <= 32'h0000_0000;
      fast_cnt <= 32'h0000_0000;
      red_cnt  <= 32'h0000_0000;
      slow_ph  <= 1'b0;
      fast_ph  <= 1'b0;
      red_ph   <= 1'b0;
    end else begin
      slow_cnt <= (slow_cnt >= SLOW_CYC - 1) ? 32'h0000_0000 : slow_cnt + 32'h0000_0001;
      fast_cnt <= (fast_cnt >= FAST_CYC - 1) ? 32'h0000_0000 : fast_cnt + 32'h0000_0001;
      red_cnt  <= (red_cnt >= RED_CYC - 1) ? 32'h0000_0000 : red_cnt + 32'h0000_0001;
      if (slow_cnt >= SLOW_CYC - 1)
        slow_ph <= ~slow_ph;
      if (fast_cnt >= FAST_CYC - 1)
        fast_ph <= ~fast_ph;
      if (red_cnt >= RED_CYC - 1)
        red_ph <= ~red_ph;
    end
  end

  // green toggles per frame, never sooner than the minimum gap
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      green_cnt  <= 32'h0000_0000;
      green_ph   <= 1'b0;
      frame_seen <= 1'b0;
    end else begin
      if (green_cnt < GREEN_CYC - 1)
        green_cnt <= green_cnt + 32'h0000_0001;
      if (FRAME_DONE_IN)
        frame_seen <= 1'b1;
      if ((FRAME_DONE_IN || frame_seen) && green_cnt >= GREEN_CYC - 1) begin
        green_ph   <= ~green_ph;
        green_cnt  <= 32'h0000_0000;
        frame_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // power-up red and fatal restart timer
  // ----------------------------------------
  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      powered    <= 1'b0;
      power_cnt  <= 32'h0000_0000;
      reboot_cnt <= 32'h0000_0000;
      REBOOT_OUT <= 1'b0;
    end else begin
      if (power_cnt >= POWER_CYC - 1)
        powered <= 1'b1;
      else
        power_cnt <= power_cnt + 32'h0000_0001;
      // restart well inside a minute; counter parks past the match so it pulses once
      REBOOT_OUT <= fatal && reboot_cnt == REBOOT_CYC - 1;
      if (!fatal)
        reboot_cnt <= 32'h0000_0000;
      else if (reboot_cnt < REBOOT_CYC)
        reboot_cnt <= reboot_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // led priority
  // ----------------------------------------
  always @* begin
    next_r = 1'b0;
    next_g = 1'b0;
    next_b = 1'b0;
    if (fatal) begin
      next_r = 1'b1;
      next_b = slow_ph;
    end else if (!powered) begin
      next_r = 1'b1;
    end else if (!init_done) begin
      next_r = red_ph;
    end else if (cond[`CSL_COND_XFER]) begin
      next_b = fast_ph;
    end else if (!LINK_UP_IN) begin
      next_b = slow_ph;
    end else if (state != ST_DONE) begin
      next_b = slow_ph;
    end else if (cond[`CSL_COND_ACQ]) begin
      next_g = green_ph;
    end else if (cond[`CSL_COND_APP]) begin
      next_g = 1'b1;
    end else begin
      next_b = 1'b1;
    end
  end

  always @(posedge CLK_IN) begin
    if (SRST_IN) begin
      LED_RED_OUT   <= 1'b1;
      LED_GREEN_OUT <= 1'b0;
      LED_BLUE_OUT  <= 1'b0;
    end else begin
      LED_RED_OUT   <= next_r;
      LED_GREEN_OUT <= next_g;
      LED_BLUE_OUT  <= next_b;
    end
  end

endmodule // csl_status_ip

/* File: verif/csl_status_chk_sva.sv */
`timescale 1ns/1ps
module csl_status_chk (
  input logic CLK_IN,
  input logic SRST_IN,
  input logic LINK_UP_IN,
  input logic LED_RED_OUT,
  input logic LED_GREEN_OUT,
  input logic LED_BLUE_OUT,
  input logic DHCP_REQ_OUT,
  input logic ARP_PROBE_OUT,
  input logic HOST_ACCESS_OUT,
  input logic REBOOT_OUT
);
  // ----------------------------------------
  // led and address sequencing checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_red;
    LED_RED_OUT && !LED_BLUE_OUT && !LED_GREEN_OUT;
  endsequence
  sequence s_no_host;
    !HOST_ACCESS_OUT;
  endsequence
  property p_pwr_red;
    $fell(SRST_IN) |-> s_red [*6];
  endproperty
  property p_fatal;
    $rose(LED_RED_OUT && LED_BLUE_OUT) |-> ##[0:60] REBOOT_OUT;
  endproperty
  property p_reboot;
    REBOOT_OUT |=> !REBOOT_OUT;
  endproperty
  property p_green;
    LED_GREEN_OUT |-> !LED_RED_OUT && !LED_BLUE_OUT;
  endproperty
  property p_probe;
    ARP_PROBE_OUT |-> s_no_host [*8];
  endproperty
  property p_dhcp;
    DHCP_REQ_OUT |-> s_no_host ##1 s_no_host;
  endproperty
  property p_down;
    $fell(LINK_UP_IN) |-> ##[1:4] s_no_host;
  endproperty
  property p_host_led;
    $rose(HOST_ACCESS_OUT) |-> ##[0:3] (LED_BLUE_OUT && !LED_RED_OUT);
  endproperty
  a_pwr_red: assert property (p_pwr_red)
    else $error("red not steady after reset");
  a_fatal: assert property (p_fatal)
    else $error("no restart request after fatal pattern");
  a_reboot: assert property (p_reboot)
    else $error("restart request longer than one cycle");
  a_green: assert property (p_green)
    else $error("green mixed with another colour");
  a_probe: assert property (p_probe)
    else $error("address taken too soon after probe");
  a_dhcp: assert property (p_dhcp)
    else $error("address held while requesting one");
  a_down: assert property (p_down)
    else $error("host access kept after cable loss");
  a_host_led: assert property (p_host_led)
    else $error("no steady blue once address assigned");
endmodule // csl_status_chk

bind csl_status_ip csl_status_chk u_chk (
  .CLK_IN(CLK_IN),
  .SRST_IN(SRST_IN),
  .LINK_UP_IN(LINK_UP_IN),
  .LED_RED_OUT(LED_RED_OUT),
  .LED_GREEN_OUT(LED_GREEN_OUT),
  .LED_BLUE_OUT(LED_BLUE_OUT),
  .DHCP_REQ_OUT(DHCP_REQ_OUT),
  .ARP_PROBE_OUT(ARP_PROBE_OUT),
  .HOST_ACCESS_OUT(HOST_ACCESS_OUT),
  .REBOOT_OUT(REBOOT_OUT)
);

/* File: verif/csl_host_link.sv */
`timescale 1ns/1ps
module csl_host_link #(
  parameter FC_EN = 1
) (
  input  logic clk_in,
  input  logic link_cmd_in,
  input  logic pause_cmd_in,
  input  logic clash_in,
  input  logic dhcp_req_in,
  input  logic arp_probe_in,
  output logic link_up_out,
  output logic pause_rx_out,
  output logic offer_out,
  output logic reply_out
);
  // ----------------------------------------
  // adapter, switch and server behaviour
  // ----------------------------------------
  initial begin
    link_up_out = 1'b0;
    pause_rx_out = 1'b0;
    offer_out = 1'b0;
    reply_out = 1'b0;
  end
  always @(posedge clk_in) begin
    link_up_out <= link_cmd_in;
    // no pause frames unless flow control is on
    pause_rx_out <= pause_cmd_in && (FC_EN != 0);
    if (dhcp_req_in)
      offer_out <= 1'b1;
    // clash models another station owning the candidate
    if (arp_probe_in && clash_in)
      reply_out <= 1'b1;
  end
endmodule // csl_host_link

/* File: verif/csl_status_ip_bench.sv */
`timescale 1ns/1ps
`include "csl_defines.vh"
module csl_status_ip_bench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        link_cmd = 1'b0;
  logic        pause_cmd = 1'b0;
  logic        clash = 1'b0;
  logic        frame = 1'b0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready, perr, e, link_up, pause_rx, offer, reply;
  logic        led_r, led_g, led_b, dhcp_req, arp, host, nr, reboot, irq;
  int          n_fail = 0;
  int          checked = 0;
  int          n_dhcp = 0;
  int          n_arp = 0;
  int          tr, tg, tb, bf, k, a;
  // scaled-down timing so every pattern shows within a short run
  localparam int T_GREEN  = 20;
  localparam int T_SLOW   = 40;
  localparam int T_FAST   = 10;
  localparam int T_RED    = 16;
  localparam int T_POWER  = 8;
  localparam int T_REBOOT = 50;
  localparam int T_WAIT   = 30;
  localparam logic [44:0] ROWS [7] = '{
    {1'b0, `CSL_OFF_CTRL, 32'h2},
    {1'b0, `CSL_OFF_COND, 32'h0},
    {1'b0, `CSL_OFF_STATUS, 32'h80},
    {1'b0, `CSL_OFF_IRQ_STAT, 32'h0},
    {1'b0, `CSL_OFF_IRQ_MASK, 32'h0},
    {1'b0, `CSL_OFF_PAUSE_CNT, 32'h0},
    {1'b1, 12'h024, 32'h0}};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_dhcp <= n_dhcp + int'(dhcp_req === 1'b1);
    n_arp  <= n_arp + int'(arp === 1'b1);
  end
  csl_status_ip #(.GREEN_CYC(T_GREEN), .SLOW_CYC(T_SLOW), .FAST_CYC(T_FAST),
    .RED_CYC(T_RED), .POWER_CYC(T_POWER), .REBOOT_CYC(T_REBOOT), .WAIT_CYC(T_WAIT)) u_dut (
    .CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .LINK_UP_IN(link_up),
    .PAUSE_RX_IN(pause_rx), .FRAME_DONE_IN(frame), .LED_RED_OUT(led_r),
    .LED_GREEN_OUT(led_g), .LED_BLUE_OUT(led_b), .DHCP_REQ_OUT(dhcp_req),
    .ARP_PROBE_OUT(arp), .HOST_ACCESS_OUT(host), .NON_ROUTABLE_OUT(nr),
    .REBOOT_OUT(reboot), .IRQ_OUT(irq));
  csl_host_link u_link (.clk_in(clk), .link_cmd_in(link_cmd),
    .pause_cmd_in(pause_cmd), .clash_in(clash), .dhcp_req_in(dhcp_req),
    .arp_probe_in(arp), .link_up_out(link_up), .pause_rx_out(pause_rx),
    .offer_out(offer), .reply_out(reply));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // extra edge after release keeps strobes from being driven twice at once
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic edges(input int c);
    logic [2:0] p;
    tr = 0;
    tg = 0;
    tb = 0;
    repeat (c) begin
      p = {led_r, led_g, led_b};
      @(posedge clk);
      tr += int'(led_r !== p[2]);
      tg += int'(led_g !== p[1]);
      tb += int'(led_b !== p[0]);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chb(led_r, 1'b1);
    edges(60);
    chb(tr >= 2, 1'b1);
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i][43:32], 32'h0);
      chb(e, ROWS[i][44]);
      if (!ROWS[i][44])
        chk(r, ROWS[i][31:0]);
    end
    $display("reset values done");
    link_cmd <= 1'b1;
    apb(1'b1, `CSL_OFF_CTRL, 32'h6);
    for (k = 0; k < 100 && offer !== 1'b1; k++) @(posedge clk);
    chb(offer, 1'b1);
    apb(1'b0, `CSL_OFF_STATUS, 32'h0);
    chk({25'h0, r[7:1]}, 32'h4);
    apb(1'b1, `CSL_OFF_STORED, 32'h0a00_0005);
    apb(1'b1, `CSL_OFF_NET, 32'h1);
    for (k = 0; k < 50 && host !== 1'b1; k++) @(posedge clk);
    chb(host, 1'b1);
    chb(nr, 1'b0);
    apb(1'b0, `CSL_OFF_ADDR, 32'h0);
    chk(r, 32'h0a00_0005);
    edges(60);
    chk(tb, 32'h0);
    chb(led_b, 1'b1);
    $display("dhcp done");
    apb(1'b1, `CSL_OFF_COND, 32'h4);
    edges(20);
    chb(led_g, 1'b1);
    apb(1'b1, `CSL_OFF_COND, 32'hc);
    frame <= 1'b1;
    edges(200);
    chb(tg >= 2 && tg <= 11, 1'b1);
    apb(1'b1, `CSL_OFF_COND, 32'he);
    edges(120);
    bf = tb;
    chb(led_g, 1'b0);
    chb(bf >= 5, 1'b1);
    frame <= 1'b0;
    apb(1'b1, `CSL_OFF_COND, 32'h0);
    link_cmd <= 1'b0;
    edges(160);
    chb(host, 1'b0);
    chb(tb >= 2 && tb < bf, 1'b1);
    $display("led priority done");
    apb(1'b1, `CSL_OFF_CTRL, 32'h4);
    clash <= 1'b1;
    link_cmd <= 1'b1;
    for (k = 0; k < 200 && reply !== 1'b1; k++) @(posedge clk);
    clash <= 1'b0;
    a = n_arp;
    apb(1'b1, `CSL_OFF_NET, 32'h2);
    for (k = 0; k < 100 && host !== 1'b1; k++) @(posedge clk);
    chk(32'(n_arp - a), 32'h1);
    chb(host, 1'b1);
    chb(nr, 1'b1);
    apb(1'b0, `CSL_OFF_ADDR, 32'h0);
    chk({16'h0, r[31:16]}, {16'h0, `CSL_LL_NET});
    $display("self assignment done");
    link_cmd <= 1'b0;
    repeat (4) @(posedge clk);
    a = n_dhcp;
    apb(1'b1, `CSL_OFF_CTRL, 32'h7);
    link_cmd <= 1'b1;
    for (k = 0; k < 50 && host !== 1'b1; k++) @(posedge clk);
    chb(host, 1'b1);
    chk(32'(n_dhcp - a), 32'h0);
    apb(1'b0, `CSL_OFF_ADDR, 32'h0);
    chk(r, 32'h0a00_0005);
    apb(1'b1, `CSL_OFF_CTRL, 32'hf);
    chb(host, 1'b0);
    apb(1'b0, `CSL_OFF_CTRL, 32'h0);
    chk(r, 32'h7);
    chb(host, 1'b1);
    $display("stored address done");
    repeat (3) begin
      pause_cmd <= 1'b1;
      @(posedge clk);
      pause_cmd <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    chb(irq, 1'b0);
    apb(1'b0, `CSL_OFF_PAUSE_CNT, 32'h0);
    chk(r, 32'h3);
    apb(1'b1, `CSL_OFF_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chb(irq, 1'b1);
    apb(1'b1, `CSL_OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chb(irq, 1'b0);
    $display("pause event done");
    apb(1'b1, `CSL_OFF_COND, 32'h1);
    for (k = 0; k < 100 && reboot !== 1'b1; k++) @(posedge clk);
    chb(reboot, 1'b1);
    chb(led_r, 1'b1);
    $display("fatal done");
    stop_test;
  end
endmodule // csl_status_ip_bench
